// ===== rct_map.svh
/*
 * Constants of the residual current trip output block: thresholds,
 * recovery levels, self-test window and monitoring pwm timing.
 * Assumes a 25 MHz core clock and currents in units of 0.1 mA.
 */
`ifndef RCT_MAP_SVH
`define RCT_MAP_SVH

// ****************************************************************
// clock and time base
// ****************************************************************
`define RCT_CLK_HZ          25000000
`define RCT_MS_PER_S        1000
`define RCT_CYC_PER_MS      (`RCT_CLK_HZ / `RCT_MS_PER_S)

// ****************************************************************
// self-test pulse window, milliseconds
// ****************************************************************
`define RCT_TEST_MIN_MS     40
`define RCT_TEST_MAX_MS     1200

// ****************************************************************
// current thresholds, 0.1 mA units
// ****************************************************************
`define RCT_DC_TRIP         16'h003C
`define RCT_DC_RECOVER      16'h0019
`define RCT_RMS30_TRIP      16'h012C
`define RCT_RMS20_TRIP      16'h00C8
`define RCT_RMS_RECOVER     16'h0064

// ****************************************************************
// monitoring pwm: 8 kHz, 2 percent per mA
// ****************************************************************
`define RCT_PWM_HZ          8000
`define RCT_PWM_PERIOD      (`RCT_CLK_HZ / `RCT_PWM_HZ)
`define RCT_PCT_PER_MA      2
`define RCT_PCT_FULL        100

`endif

// ===== rct_pkg.sv
/*
 * Types of the residual current trip output block.
 * Assumes rct_map.svh is compiled alongside for the constants.
 */
package rct_pkg;

   // measurement sample from the analog front end, 0.1 mA units
   typedef struct packed {
      logic [15:0] dc_abs;
      logic [15:0] rms;
   } rct_meas_t;

   // self-test sequencer states
   typedef enum logic [1:0] {
      RCT_IDLE    = 2'b00,
      RCT_MEASURE = 2'b01,
      RCT_TEST    = 2'b10
   } rct_state_t;

endpackage : rct_pkg

// ===== rct_trip.sv
/*
 * Trip outputs, fault output, self-test sequencer and dc monitor pwm
 * of a residual current sensor.
 * Assumes the analog front end delivers absolute dc and rms current
 * samples synchronous to ref_clk_i, and that pins are open collector
 * with external pull-ups (oe low means pin pulled to ground).
 */
// What this block does
// RULE1: with no fault the fault pin is pulled low, on a fault it floats.
// RULE2: a fault forces both trip pins to float whatever the current.
// RULE3: a self-test low pulse of 40 ms to 1.2 s starts test and offset.
// RULE4: a low pulse shorter than 40 ms or longer than 1.2 s is ignored.
// RULE5: the offset found by the test is stored and used afterwards.
// RULE6: the host keeps differential current away during the test.
// RULE7: the host should request the test regularly, e.g. at startup.
// RULE8: the 6/30 trip pin is pulled low only while dc stays below 6 mA.
// RULE9: the 6/30 trip pin also needs rms below 30 mA to stay low.
// RULE10: in every other case the 6/30 trip pin floats.
// RULE11: the 20 trip pin is low only with rms below 20 mA and no fault.
// RULE12: an 8 kHz pwm on the dc level pin follows the dc component.
// RULE13: the pwm duty rises by 2 percent per mA of dc current.
// RULE14: the host uses the pwm for monitoring, never relay switching.
// RULE15: a tripped pin releases only below 2.5 mA dc or 10 mA rms.
// RULE16: a tripped pin stays floating while above its recovery level.
// RULE17: the low pulse is timed in ms from fall to rise, test after rise.
`timescale 1ns/10ps
`default_nettype none
`include "rct_map.svh"

module rct_trip #(
   parameter int unsigned TEST_MIN_MS = `RCT_TEST_MIN_MS,
   parameter int unsigned TEST_MAX_MS = `RCT_TEST_MAX_MS,
   parameter int unsigned CYC_PER_MS  = `RCT_CYC_PER_MS,
   parameter int unsigned TEST_CYC    = `RCT_CYC_PER_MS
) (
   // clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rstn_i,
   // analog front end
   input  wire rct_pkg::rct_meas_t meas_i,
   input  wire logic              sys_fault_i,
   // self-test request pin, low active
   input  wire logic              self_test_request_n_i,
   // open collector pins: oe low pulls pin to ground
   output logic                   fault_flag_out_o,
   output logic                   fault_flag_out_oe_o,
   output logic                   trip_dc6_ac30_out_o,
   output logic                   trip_dc6_ac30_out_oe_o,
   output logic                   trip_ac20_out_o,
   output logic                   trip_ac20_out_oe_o,
   // monitoring pwm and test status
   output logic                   dc_level_duty_out_o,
   output logic                   test_busy_o,
   output logic [15:0]            offset_o
);

   // ****************************************************************
   // parameter checks
   // ****************************************************************
   // the ms divider needs at least two cycles per ms
   if (TEST_MIN_MS == 0 || TEST_MIN_MS >= TEST_MAX_MS ||
       TEST_MAX_MS >= 65535 || CYC_PER_MS < 2 ||
       TEST_CYC == 0) begin : g_bad_param
      $error("rct_trip: bad timing parameters");
   end

   localparam int unsigned PWM_PER = `RCT_PWM_PERIOD;

   // returns true while a current sits at or above a level
   function automatic logic rct_at_or_above(input logic [15:0] val,
                                            input logic [15:0] lvl);
      rct_at_or_above = (val >= lvl);
   endfunction : rct_at_or_above

   // ****************************************************************
   // offset correction and trip latches
   // ****************************************************************
   logic [15:0] offset_reg, offset_next;
   logic [15:0] dc_corr;
   logic        trip630_reg, trip630_next;
   logic        trip20_reg,  trip20_next;

   // subtract the stored offset, clamp at zero
   assign dc_corr = (meas_i.dc_abs > offset_reg) ?
                    meas_i.dc_abs - offset_reg : 16'h0000; // see RULE5

   // trip with hysteresis down to the recovery level
   always_comb begin
      trip630_next = trip630_reg;
      trip20_next  = trip20_reg;
      if (rct_at_or_above(dc_corr, `RCT_DC_TRIP) ||            // see RULE8
          rct_at_or_above(meas_i.rms, `RCT_RMS30_TRIP))        // see RULE9
         trip630_next = 1'b1;                                  // see RULE10
      else if (!rct_at_or_above(dc_corr, `RCT_DC_RECOVER) &&
               !rct_at_or_above(meas_i.rms, `RCT_RMS_RECOVER))
         trip630_next = 1'b0;                                  // see RULE15
      if (rct_at_or_above(meas_i.rms, `RCT_RMS20_TRIP))
         trip20_next = 1'b1;                                   // see RULE11
      else if (!rct_at_or_above(meas_i.rms, `RCT_RMS_RECOVER))
         trip20_next = 1'b0;                                   // see RULE16
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         trip630_reg <= 1'b0;
         trip20_reg  <= 1'b0;
      end else begin
         trip630_reg <= trip630_next;
         trip20_reg  <= trip20_next;
      end
   end

   // ****************************************************************
   // self-test sequencer
   // ****************************************************************
   rct_pkg::rct_state_t state_reg, state_next;
   logic [15:0] ms_reg, ms_next;       // whole ms of the low pulse
   logic [31:0] cyc_reg, cyc_next;     // cycles within a ms or test
   logic        req_d_reg, req_d_next;
   logic        rise;

   assign rise = self_test_request_n_i && !req_d_reg;

   // time the low pulse, qualify it, then run test and take offset
   always_comb begin
      state_next  = state_reg;
      ms_next     = ms_reg;
      cyc_next    = cyc_reg;
      offset_next = offset_reg;
      req_d_next  = self_test_request_n_i;
      case (state_reg)
         rct_pkg::RCT_IDLE: begin
            ms_next  = 16'h0000;
            cyc_next = 32'h0000_0000;
            if (!self_test_request_n_i && req_d_reg) begin
               // the cycle of the fall is part of the low time
               cyc_next   = 32'h0000_0001;
               state_next = rct_pkg::RCT_MEASURE;              // see RULE17
            end
         end
         rct_pkg::RCT_MEASURE: begin
            if (rise) begin
               cyc_next = 32'h0000_0000;
               if (ms_reg >= 16'(TEST_MIN_MS) &&
                   ms_reg <= 16'(TEST_MAX_MS))
                  state_next = rct_pkg::RCT_TEST;              // see RULE3
               else
                  state_next = rct_pkg::RCT_IDLE;              // see RULE4
            end else if (cyc_reg == 32'(CYC_PER_MS - 1)) begin
               cyc_next = 32'h0000_0000;
               if (ms_reg != 16'hFFFF)
                  ms_next = ms_reg + 16'h0001;                 // see RULE17
            end else begin
               cyc_next = cyc_reg + 32'h0000_0001;
            end
         end
         rct_pkg::RCT_TEST: begin
            cyc_next = cyc_reg + 32'h0000_0001;
            if (cyc_reg == 32'(TEST_CYC - 1)) begin
               offset_next = meas_i.dc_abs;                    // see RULE5
               state_next  = rct_pkg::RCT_IDLE;
            end
         end
         default: state_next = rct_pkg::RCT_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg  <= rct_pkg::RCT_IDLE;
         ms_reg     <= 16'h0000;
         cyc_reg    <= 32'h0000_0000;
         offset_reg <= 16'h0000;
         req_d_reg  <= 1'b1;
      end else begin
         state_reg  <= state_next;
         ms_reg     <= ms_next;
         cyc_reg    <= cyc_next;
         offset_reg <= offset_next;
         req_d_reg  <= req_d_next;
      end
   end

   // ****************************************************************
   // monitoring pwm
   // ****************************************************************
   logic [15:0] pwm_cnt_reg, pwm_cnt_next;
   logic        pwm_reg,     pwm_next;
   logic [31:0] duty_cyc;

   // duty = dc(0.1mA) * 2%/mA * period / (10 * 100)
   assign duty_cyc = (32'(dc_corr) * 32'(`RCT_PCT_PER_MA) * 32'(PWM_PER))
                     / 32'(10 * `RCT_PCT_FULL);               // see RULE13

   always_comb begin
      pwm_cnt_next = (pwm_cnt_reg == 16'(PWM_PER - 1)) ?
                     16'h0000 : pwm_cnt_reg + 16'h0001;        // see RULE12
      pwm_next     = (32'(pwm_cnt_reg) < duty_cyc);
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pwm_cnt_reg <= 16'h0000;
         pwm_reg     <= 1'b0;
      end else begin
         pwm_cnt_reg <= pwm_cnt_next;
         pwm_reg     <= pwm_next;
      end
   end

   // ****************************************************************
   // pin drive
   // ****************************************************************
   assign fault_flag_out_o       = 1'b0;
   assign trip_dc6_ac30_out_o    = 1'b0;
   assign trip_ac20_out_o        = 1'b0;
   assign fault_flag_out_oe_o    = sys_fault_i;                // see RULE1
   assign trip_dc6_ac30_out_oe_o = sys_fault_i || trip630_reg; // see RULE2
   assign trip_ac20_out_oe_o     = sys_fault_i || trip20_reg;  // see RULE2
   assign dc_level_duty_out_o    = pwm_reg;
   assign test_busy_o            = (state_reg == rct_pkg::RCT_TEST);
   assign offset_o               = offset_reg;

endmodule : rct_trip
`default_nettype wire

// ===== rct_host_model.sv
/* host side model: pull-ups on the open collector pins, relay drive.
   assumes oe high means the pin floats. */
`timescale 1ns/10ps
`default_nettype none
module rct_host_model (
   // pin enables from the sensor
   input  wire logic fault_oe_i,
   input  wire logic trip6_oe_i,
   input  wire logic trip20_oe_i,
   // pin drive values from the sensor
   input  wire logic fault_drv_i,
   input  wire logic trip6_drv_i,
   input  wire logic trip20_drv_i,
   // pin levels and relay
   output logic      fault_pin_o,
   output logic      trip6_pin_o,
   output logic      trip20_pin_o,
   output logic      relay_on_o
);
   // a floating pin is pulled high, a driven pin shows the drive value
   assign fault_pin_o  = fault_oe_i ? 1'b1 : fault_drv_i;
   assign trip6_pin_o  = trip6_oe_i ? 1'b1 : trip6_drv_i;
   assign trip20_pin_o = trip20_oe_i ? 1'b1 : trip20_drv_i;
   // relay from trip and fault pins only, never the pwm
   assign relay_on_o = !(fault_pin_o | trip6_pin_o | trip20_pin_o);
endmodule : rct_host_model
`default_nettype wire

// ===== rct_trip_properties.sv
/* port assertions of rct_trip.
   assumes one clock domain; bound below. */
`timescale 1ns/10ps
`default_nettype none
module rct_trip_chk #(
   parameter int unsigned TEST_MIN_MS = 40,
   parameter int unsigned TEST_MAX_MS = 1200,
   parameter int unsigned CYC_PER_MS  = 25000
) (
   // clock, reset and inputs
   input wire logic               ref_clk_i,
   input wire logic               rstn_i,
   input wire rct_pkg::rct_meas_t meas_i,
   input wire logic               sys_fault_i,
   input wire logic               self_test_request_n_i,
   // outputs watched
   input wire logic               fault_flag_out_oe_o,
   input wire logic               trip_dc6_ac30_out_oe_o,
   input wire logic               trip_ac20_out_oe_o,
   input wire logic               test_busy_o,
   input wire logic [15:0]        offset_o
);
   logic [31:0] low_reg;
   logic        ok_len;
   logic        bad_len;
   // cycles the test pin has been low
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) low_reg <= '0;
      else low_reg <= self_test_request_n_i ? '0 : low_reg + 1;
   end
   // lengths inside and outside the window, bounded exactly at its edges
   assign ok_len = low_reg >= TEST_MIN_MS * CYC_PER_MS &&
                   low_reg < (TEST_MAX_MS + 1) * CYC_PER_MS;
   assign bad_len = low_reg < TEST_MIN_MS * CYC_PER_MS ||
                    low_reg >= (TEST_MAX_MS + 1) * CYC_PER_MS;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // end of a low pulse while no test runs
   sequence rise_s;
      $rose(self_test_request_n_i) && !test_busy_o;
   endsequence
   fault_rel_a: assert property (
      sys_fault_i |-> fault_flag_out_oe_o) else $error("fault pin low");
   fault_trip_a: assert property (
      sys_fault_i |-> trip_dc6_ac30_out_oe_o && trip_ac20_out_oe_o)
      else $error("trip pin low on fault");
   dc_trip_a: assert property (
      {1'b0, meas_i.dc_abs} >= {1'b0, offset_o} + 17'h0003C
      |=> trip_dc6_ac30_out_oe_o) else $error("dc trip missed");
   rms30_trip_a: assert property (
      meas_i.rms >= 16'h012C |=> trip_dc6_ac30_out_oe_o)
      else $error("rms30 trip missed");
   rms20_trip_a: assert property (
      meas_i.rms >= 16'h00C8 |=> trip_ac20_out_oe_o)
      else $error("rms20 trip missed");
   trip_hold_a: assert property (
      trip_ac20_out_oe_o && !sys_fault_i && meas_i.rms >= 16'h0064
      |=> trip_ac20_out_oe_o) else $error("trip released early");
   test_start_a: assert property (
      rise_s ##0 ok_len |=> test_busy_o) else $error("test not started");
   test_skip_a: assert property (
      rise_s ##0 bad_len |=> !test_busy_o) else $error("test started");
endmodule : rct_trip_chk
bind rct_trip rct_trip_chk #(.TEST_MIN_MS(TEST_MIN_MS),
   .TEST_MAX_MS(TEST_MAX_MS), .CYC_PER_MS(CYC_PER_MS)) chk_inst (
   .ref_clk_i, .rstn_i, .meas_i, .sys_fault_i, .self_test_request_n_i,
   .fault_flag_out_oe_o, .trip_dc6_ac30_out_oe_o, .trip_ac20_out_oe_o,
   .test_busy_o, .offset_o);
`default_nettype wire

// ===== tb_top.sv
/* testbench of rct_trip with the host model.
   assumes a shortened ms time base of 10 cycles. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   localparam int CYC = 10;
   logic ref_clk_i = 0, rstn_i = 0, fault_i = 0, req_n = 1;
   logic f_oe, t6_oe, t20_oe, pwm, busy, fpin, p6, p20, relay;
   logic f_drv, t6_drv, t20_drv;
   logic [15:0] offset;
   rct_pkg::rct_meas_t meas = '0;
   int num_errors = 0, tests_run = 0, cyc = 0;
   // clock and timeout
   always #20 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         test_done();
      end
   end
   rct_trip #(.CYC_PER_MS(CYC), .TEST_CYC(5)) rct_trip_inst (
      .ref_clk_i, .rstn_i, .meas_i(meas), .sys_fault_i(fault_i),
      .self_test_request_n_i(req_n), .fault_flag_out_o(f_drv),
      .fault_flag_out_oe_o(f_oe), .trip_dc6_ac30_out_o(t6_drv),
      .trip_dc6_ac30_out_oe_o(t6_oe), .trip_ac20_out_o(t20_drv),
      .trip_ac20_out_oe_o(t20_oe), .dc_level_duty_out_o(pwm),
      .test_busy_o(busy), .offset_o(offset));
   rct_host_model rct_host_model_inst (.fault_oe_i(f_oe),
      .trip6_oe_i(t6_oe), .trip20_oe_i(t20_oe), .fault_drv_i(f_drv),
      .trip6_drv_i(t6_drv), .trip20_drv_i(t20_drv), .fault_pin_o(fpin),
      .trip6_pin_o(p6), .trip20_pin_o(p20), .relay_on_o(relay));
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : tick
   task automatic chk(input logic [15:0] got, exp, input string m);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   task automatic cur(input int dc, rms);
      meas.dc_abs = dc[15:0];
      meas.rms = rms[15:0];
      tick(2);
   endtask : cur
   task automatic t_fault;
      fault_i = 1;
      tick(1);
      chk(16'({fpin, p6, p20}), 16'h0007, "fault pins");
      fault_i = 0;
      tick(1);
      chk(16'({fpin, relay}), 16'h0001, "fault clear");
      $display("test fault done");
   endtask : t_fault
   task automatic t_trip;
      int tv [9][4] = '{'{59, 0, 0, 0}, '{60, 0, 1, 0}, '{30, 0, 1, 0},
         '{24, 0, 0, 0}, '{0, 299, 0, 1}, '{0, 300, 1, 1}, '{0, 150, 1, 1},
         '{0, 99, 0, 0}, '{0, 199, 0, 0}};
      logic [15:0] e, pp;
      foreach (tv[i]) begin
         cur(tv[i][0], tv[i][1]);
         e = 16'(tv[i][2] * 2 + tv[i][3]);
         pp = 16'({p6, p20});
         chk(pp, e, "trip");
      end
      $display("test trip done");
   endtask : t_trip
   task automatic t_pulse(input int ms, input logic exp);
      req_n = 0;
      tick(ms * CYC);
      req_n = 1;
      tick(2);
      chk(16'(busy), 16'(exp), "self test");
      tick(10);
   endtask : t_pulse
   task automatic t_test;
      cur(7, 0); // only offset current during the test
      t_pulse(39, 0);
      t_pulse(40, 1);
      chk(offset, 16'h0007, "offset");
      t_pulse(1200, 1);
      t_pulse(1201, 0);
      cur(66, 0);
      chk(16'(p6), 16'h0000, "offset below");
      cur(67, 0);
      chk(16'(p6), 16'h0001, "offset trip");
      $display("test self test done");
   endtask : t_test
   task automatic t_pwm;
      int hi = 0, per = 0;
      cur(57, 0);
      while (pwm !== 1'b0) tick(1);
      while (pwm !== 1'b1) tick(1);
      while (pwm === 1'b1) begin
         hi++;
         tick(1);
      end
      per = hi;
      while (pwm !== 1'b1) begin
         per++;
         tick(1);
      end
      chk(16'(per), 16'h0C35, "pwm period");
      chk(16'(hi), 16'h0138, "pwm duty");
      $display("test pwm done");
   endtask : t_pwm
   task automatic test_done;
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   // main sequence
   initial begin
      tick(20);
      rstn_i = 1;
      tick(2);
      t_fault();
      t_trip();
      t_test();
      t_pwm();
      test_done();
   end
endmodule : tb_top
`default_nettype wire
